//--- hdl/dmmci_pkg.sv
// dmmci_pkg: shared constants and types for the multimeter command interpreter.
// assumes a word-serial front end has already decoded commands into opcodes.
`default_nettype none
package dmmci_pkg;
  // command opcodes delivered by the word-serial decoder
  typedef enum logic [3:0] {
    DMMCI_CMD_NONE      = 4'h0,
    DMMCI_CMD_TRIG_READ = 4'h1,
    DMMCI_CMD_ZERO      = 4'h2,
    DMMCI_CMD_OPC       = 4'h3,
    DMMCI_CMD_OPC_QRY   = 4'h4,
    DMMCI_CMD_PUD_STORE = 4'h5,
    DMMCI_CMD_PUD_QRY   = 4'h6,
    DMMCI_CMD_RESET     = 4'h7,
    DMMCI_CMD_SRE_WR    = 4'h8,
    DMMCI_CMD_SRE_QRY   = 4'h9
  } dmmci_cmd_type;

  // response kinds placed in the output queue
  typedef enum logic [2:0] {
    DMMCI_RSP_READING  = 3'h0,
    DMMCI_RSP_OPEN     = 3'h1,
    DMMCI_RSP_OVERLOAD = 3'h2,
    DMMCI_RSP_INTEGER  = 3'h3,
    DMMCI_RSP_PUD_BYTE = 3'h4
  } dmmci_rsp_type;

  // control states of the interpreter
  typedef enum logic [2:0] {
    DMMCI_ST_IDLE   = 3'b000,
    DMMCI_ST_ACQ    = 3'b001,
    DMMCI_ST_ZERO   = 3'b010,
    DMMCI_ST_OPCW   = 3'b011,
    DMMCI_ST_PUDWR  = 3'b100,
    DMMCI_ST_PUDRD  = 3'b101
  } dmmci_state_type;

  localparam int          DMMCI_SRE_W        = 8;
  localparam int          DMMCI_SRE_MAX      = 255;     // highest legal enable value
  localparam int          DMMCI_SRE_RQS_BIT  = 6;
  localparam int          DMMCI_SRE_ESB_BIT  = 5;
  localparam int          DMMCI_SRE_MAV_BIT  = 4;
  localparam logic [7:0]  DMMCI_SRE_USED     = 8'h70;   // bits 6,5,4 implemented
  localparam logic [7:0]  DMMCI_SRE_RST      = 8'h00;
  localparam int          DMMCI_ESR_OPC_BIT  = 0;       // operation complete
  localparam int          DMMCI_ESR_EXE_BIT  = 4;       // execution error
  localparam logic [15:0] DMMCI_INT_ZERO     = 16'h0000;
  localparam logic [15:0] DMMCI_INT_ONE      = 16'h0001;
  localparam logic [15:0] DMMCI_DATA_RST     = 16'h0000;
  localparam logic [7:0]  DMMCI_BYTE_RST     = 8'h00;
endpackage : dmmci_pkg
`default_nettype wire

//--- hdl/dmmci_pud_if.sv
// dmmci_pud_if: carries user-data store requests between interpreter and store.
// assumes both ends share mclk.
`default_nettype none
interface dmmci_pud_if #(parameter int AW = 6);
  logic          wr_en;    // write one byte
  logic [AW-1:0] addr;     // byte index
  logic [7:0]    wdata;    // byte to write
  logic [7:0]    rdata;    // byte at addr
  modport ctrl  (output wr_en, output addr, output wdata, input rdata);
  modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : dmmci_pud_if
`default_nettype wire

//--- hdl/dmmci_pud_store.sv
// dmmci_pud_store: user-data byte store kept in flip-flops.
// assumes the array stands for non-volatile storage, so reset does not touch it.
`default_nettype none
module dmmci_pud_store
  import dmmci_pkg::*;
#(
  parameter int DEPTH = 64   // bytes of user area
) (
  input wire logic   mclk,   // module clock
  dmmci_pud_if.store bus     // byte port from interpreter
);
  logic [7:0] mem_r [DEPTH];  // storage, survives reset on purpose

  // byte write, the contents outlive any reset command
  always_ff @(posedge mclk) begin
    if (bus.wr_en) begin
      mem_r[bus.addr] <= bus.wdata;
    end
  end

  assign bus.rdata = mem_r[bus.addr];
endmodule : dmmci_pud_store
`default_nettype wire

//--- hdl/dmmci_top.sv
// dmmci_top: command and status interpreter of the multimeter module.
// assumes opcodes arrive one cycle at a time from a word-serial decoder, and the
// measurement front end answers acquire and zero requests with done pulses.
`default_nettype none
module dmmci_top
  import dmmci_pkg::*;
#(
  parameter int PUD_DEPTH = 64,   // user-data bytes available
  parameter int DIAG_W    = 16    // width of one diagnostic code
) (
  input  wire logic                 mclk,             // module clock, 100 MHz
  input  wire logic                 rst_n,            // async power-on reset, active low
  input  wire logic                 cmd_valid,        // opcode strobe, one cycle
  input  wire dmmci_cmd_type        cmd_op,           // decoded command
  input  wire logic [15:0]          cmd_arg,          // integer arg or block length
  input  wire logic                 pud_byte_valid,   // one block byte strobe
  input  wire logic [7:0]           pud_byte,         // block byte
  input  wire logic                 pud_protect,      // user-data write protection
  input  wire logic                 autorange,        // autorange selected
  input  wire logic                 ac_func,          // ac function selected
  input  wire logic                 trig_ext_sel,     // trigger source set to external
  input  wire logic                 meas_done,        // acquisition finished pulse
  input  wire logic [15:0]          meas_value,       // acquired reading
  input  wire logic                 meas_open,        // input disconnected
  input  wire logic                 meas_overload,    // input in overload
  input  wire logic                 zero_done,        // zeroing finished pulse
  input  wire logic                 zero_err,         // zeroing found errors
  input  wire logic [DIAG_W-1:0]    zero_code,        // error code from zeroing
  input  wire logic [7:0]           esr_other,        // event bits owned elsewhere
  input  wire logic                 rsp_ack,          // commander took the response
  output logic                      busy,             // operation pending
  output logic                      meas_start,       // acquire pulse
  output logic                      block_abort,      // end block measurement pulse
  output logic                      zero_start,       // zeroing pulse
  output logic                      trigger_source_select, // 0 internal_system_trigger
  output logic                      diag_push,        // diagnostic_error_queue_query push
  output logic [DIAG_W-1:0]         diag_code,        // pushed code
  output logic                      exec_err,         // execution error pulse
  output logic [7:0]                esr_bits,         // opc and exe event bits, sticky
  output logic [7:0]                service_request_enable, // enable register
  output logic [7:0]                status_byte,      // assembled status byte
  output logic                      rsp_valid,        // response waiting
  output dmmci_rsp_type             rsp_kind,         // response kind
  output logic [15:0]               rsp_data,         // response value
  output logic                      inst_reset        // power-on-state pulse to instrument
);
  localparam int AW = $clog2(PUD_DEPTH);
  localparam logic [15:0] PUD_LEN = 16'(PUD_DEPTH);

  dmmci_state_type state_r;          // control state
  logic [15:0]     cnt_r;            // user-data byte counter
  logic [15:0]     len_r;            // user-data block length
  logic            opc_qry_r;        // waiting opc is the query form
  logic            err_nxt;          // execution error this cycle
  logic            soft_rst;         // reset command taken

  dmmci_pud_if #(.AW(AW)) pud ();

  dmmci_pud_store #(.DEPTH(PUD_DEPTH)) u_store (
    .mclk (mclk),
    .bus  (pud)
  );

  assign soft_rst = cmd_valid && cmd_op == DMMCI_CMD_RESET && state_r == DMMCI_ST_IDLE;

  // refusals, and open-input readings in an acquisition, that raise an execution error
  always_comb begin
    err_nxt = 1'b0;
    if (cmd_valid && state_r == DMMCI_ST_IDLE) begin
      case (cmd_op)
        DMMCI_CMD_ZERO:      err_nxt = autorange || ac_func;
        DMMCI_CMD_PUD_STORE: err_nxt = pud_protect || cmd_arg > PUD_LEN;
        DMMCI_CMD_SRE_WR:    err_nxt = cmd_arg > 16'(DMMCI_SRE_MAX);
        default:             err_nxt = 1'b0;
      endcase
    end
    if (state_r == DMMCI_ST_ACQ && meas_done && meas_open) begin
      err_nxt = 1'b1;
    end
  end

  // user-data port, writes only in a store block
  assign pud.wr_en = state_r == DMMCI_ST_PUDWR && pud_byte_valid;
  assign pud.addr  = cnt_r[AW-1:0];
  assign pud.wdata = pud_byte;

  // command sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= DMMCI_ST_IDLE;
      cnt_r     <= 16'h0000;
      len_r     <= 16'h0000;
      opc_qry_r <= 1'b0;
    end else begin
      case (state_r)
        DMMCI_ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (cmd_valid && !err_nxt) begin
            case (cmd_op)
              DMMCI_CMD_TRIG_READ: state_r <= DMMCI_ST_ACQ;
              DMMCI_CMD_ZERO:      state_r <= DMMCI_ST_ZERO;
              DMMCI_CMD_PUD_STORE: begin
                len_r   <= cmd_arg;
                state_r <= (cmd_arg == 16'h0000) ? DMMCI_ST_IDLE : DMMCI_ST_PUDWR;
              end
              DMMCI_CMD_PUD_QRY:   state_r <= DMMCI_ST_PUDRD;
              default:             state_r <= DMMCI_ST_IDLE;  // single-cycle commands
            endcase
          end
        end
        DMMCI_ST_ACQ:  if (meas_done) state_r <= DMMCI_ST_IDLE;
        DMMCI_ST_ZERO: if (zero_done) state_r <= DMMCI_ST_IDLE;
        DMMCI_ST_PUDWR: begin
          if (pud_byte_valid) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 == len_r) state_r <= DMMCI_ST_IDLE;
          end
        end
        DMMCI_ST_PUDRD: begin
          // one byte per acknowledged response, whole area returned
          if (rsp_ack) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 == PUD_LEN) state_r <= DMMCI_ST_IDLE;
          end
        end
        default: state_r <= DMMCI_ST_IDLE;
      endcase
      // opc latch: taken even while busy, answered once idle
      if (cmd_valid && (cmd_op == DMMCI_CMD_OPC || cmd_op == DMMCI_CMD_OPC_QRY)) begin
        opc_qry_r <= cmd_op == DMMCI_CMD_OPC_QRY;
      end
    end
  end

  // pending opc flag kept apart so sequencing stays simple
  logic opc_pend_r;  // opc waiting for idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opc_pend_r <= 1'b0;
    end else if (cmd_valid && (cmd_op == DMMCI_CMD_OPC || cmd_op == DMMCI_CMD_OPC_QRY)) begin
      opc_pend_r <= 1'b1;
    end else if (state_r == DMMCI_ST_IDLE) begin
      opc_pend_r <= 1'b0;
    end
  end

  // front-end strobes and busy flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meas_start  <= 1'b0;
      block_abort <= 1'b0;
      zero_start  <= 1'b0;
      busy        <= 1'b0;
      inst_reset  <= 1'b0;
    end else begin
      meas_start  <= state_r == DMMCI_ST_IDLE && cmd_valid && !err_nxt &&
                     cmd_op == DMMCI_CMD_TRIG_READ && !trig_ext_sel;
      block_abort <= state_r == DMMCI_ST_IDLE && cmd_valid &&
                     cmd_op == DMMCI_CMD_TRIG_READ;
      zero_start  <= state_r == DMMCI_ST_IDLE && cmd_valid && !err_nxt &&
                     cmd_op == DMMCI_CMD_ZERO;
      busy        <= state_r != DMMCI_ST_IDLE;
      inst_reset  <= soft_rst;
    end
  end

  // trigger source: trig_ext_sel one cycle late; internal at power-on and for one cycle on a reset command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_source_select <= 1'b0;
    end else if (soft_rst) begin
      trigger_source_select <= 1'b0;
    end else begin
      trigger_source_select <= trig_ext_sel;
    end
  end

  // zero errors go to the diagnostic queue
  // corrections live in the front end, untouched here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_push <= 1'b0;
      diag_code <= '0;
    end else begin
      diag_push <= state_r == DMMCI_ST_ZERO && zero_done && zero_err;
      diag_code <= zero_code;
    end
  end

  // execution error pulse and sticky event bits; a set beats the reset clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exec_err <= 1'b0;
      esr_bits <= 8'h00;
    end else begin
      exec_err <= err_nxt;
      if (soft_rst) begin
        esr_bits <= 8'h00;
      end
      if (err_nxt) begin
        esr_bits[DMMCI_ESR_EXE_BIT] <= 1'b1;
      end
      if (opc_pend_r && !opc_qry_r && state_r == DMMCI_ST_IDLE) begin
        esr_bits[DMMCI_ESR_OPC_BIT] <= 1'b1;
      end
    end
  end

  // service request enable register; only bits 6,5,4 are held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      service_request_enable <= DMMCI_SRE_RST;
    end else if (soft_rst) begin
      service_request_enable <= DMMCI_SRE_RST;
    end else if (cmd_valid && cmd_op == DMMCI_CMD_SRE_WR && !err_nxt &&
                 state_r == DMMCI_ST_IDLE) begin
      service_request_enable <= cmd_arg[7:0] & DMMCI_SRE_USED;
    end
  end

  // status byte: event bit 0 to bit 0, event bits 2..7 to bits 1..6, enable bit 5 to bit 7
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= {service_request_enable[DMMCI_SRE_ESB_BIT],
                      (esr_other[7:2] | esr_bits[7:2]),
                      (esr_other[0] | esr_bits[0])};
    end
  end

  // response register, held until acked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_kind  <= DMMCI_RSP_INTEGER;
      rsp_data  <= DMMCI_DATA_RST;
    end else begin
      if (rsp_ack) begin
        rsp_valid <= 1'b0;
      end
      if (state_r == DMMCI_ST_ACQ && meas_done) begin
        rsp_valid <= 1'b1;
        rsp_data  <= meas_value;
        if (meas_open) begin
          rsp_kind <= DMMCI_RSP_OPEN;
        end else if (meas_overload) begin
          rsp_kind <= DMMCI_RSP_OVERLOAD;
        end else begin
          rsp_kind <= DMMCI_RSP_READING;
        end
      end else if (state_r == DMMCI_ST_ZERO && zero_done) begin
        rsp_valid <= 1'b1;
        rsp_kind  <= DMMCI_RSP_INTEGER;
        rsp_data  <= zero_err ? DMMCI_INT_ONE : DMMCI_INT_ZERO;
      end else if (opc_pend_r && opc_qry_r && state_r == DMMCI_ST_IDLE) begin
        rsp_valid <= 1'b1;
        rsp_kind  <= DMMCI_RSP_INTEGER;
        rsp_data  <= DMMCI_INT_ONE;
      end else if (cmd_valid && cmd_op == DMMCI_CMD_SRE_QRY && state_r == DMMCI_ST_IDLE) begin
        rsp_valid <= 1'b1;
        rsp_kind  <= DMMCI_RSP_INTEGER;
        // bit 6 never read back, so answers stay inside 0..63 or 128..191
        rsp_data  <= {8'h00, service_request_enable &
                     ~(8'h01 << DMMCI_SRE_RQS_BIT)};
      end else if (state_r == DMMCI_ST_PUDRD && !rsp_valid) begin
        rsp_valid <= 1'b1;
        rsp_kind  <= DMMCI_RSP_PUD_BYTE;
        rsp_data  <= {8'h00, pud.rdata};
      end
    end
  end
endmodule : dmmci_top
`default_nettype wire

//--- testbench/dmmci_cmdr.sv
// dmmci_cmdr: behavioural system-bus commander facing the interpreter.
// assumes the bench calls its tasks just after a rising edge of mclk.
`default_nettype none
module dmmci_cmdr
  import dmmci_pkg::*;
(
  input  wire logic          mclk,           // module clock
  input  wire logic          rsp_valid,      // response waiting
  input  wire dmmci_rsp_type rsp_kind,       // response kind
  input  wire logic [15:0]   rsp_data,       // response value
  input  wire logic          slow,           // stall before taking responses
  output logic               rsp_ack,        // response taken
  output logic               cmd_valid,      // opcode strobe
  output dmmci_cmd_type      cmd_op,         // command
  output logic [15:0]        cmd_arg,        // integer or block length
  output logic               pud_byte_valid, // block byte strobe
  output logic [7:0]         pud_byte        // block byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] got_q[$]; // responses taken: kind then value
  int          wait_c;   // stall cycles left
  initial begin
    {rsp_ack, cmd_valid, pud_byte_valid, cmd_arg, pud_byte} = '0;
    cmd_op = DMMCI_CMD_NONE;
    wait_c = 0;
  end
  // take each response once; slow acks test the hold
  always @(posedge mclk) begin
    rsp_ack <= 1'b0;
    if (rsp_valid === 1'b1 && !rsp_ack) begin
      if (wait_c == 0) begin
        got_q.push_back({rsp_kind, rsp_data});
        rsp_ack <= 1'b1;
        wait_c <= slow ? 3 : 0;
      end else wait_c <= wait_c - 1;
    end
  end
  // one command word, argument scrambled after
  task automatic send(input dmmci_cmd_type op, input logic [15:0] arg);
    cmd_op    <= op;
    cmd_arg   <= arg;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_arg   <= ~arg;
    @(posedge mclk);
  endtask
  // one block byte, then a gap cycle
  task automatic put_byte(input logic [7:0] b);
    pud_byte       <= b;
    pud_byte_valid <= 1'b1;
    @(posedge mclk);
    pud_byte_valid <= 1'b0;
    pud_byte       <= ~b;
    @(posedge mclk);
  endtask
endmodule // dmmci_cmdr
`default_nettype wire

//--- testbench/dmmci_top_asserts.sv
// dmmci_top_asserts: port-level timing checks of the command interpreter.
// assumes binding onto dmmci_top; reads its ports only.
`default_nettype none
module dmmci_top_asserts
  import dmmci_pkg::*;
#(
  parameter int PUD_DEPTH = 64  // user-data bytes
) (
  input wire logic          mclk,                   // clock
  input wire logic          rst_n,                  // reset, active low
  input wire logic          cmd_valid,              // opcode strobe
  input wire dmmci_cmd_type cmd_op,                 // command
  input wire logic [15:0]   cmd_arg,                // argument
  input wire logic          pud_protect,            // write protection
  input wire logic          autorange,              // autorange mode
  input wire logic          ac_func,                // ac function
  input wire logic          trig_ext_sel,           // external trigger
  input wire logic          meas_done,              // acquisition done
  input wire logic [15:0]   meas_value,             // reading
  input wire logic          meas_open,              // input open
  input wire logic          meas_overload,          // overload
  input wire logic          zero_done,              // zeroing done
  input wire logic          zero_err,               // zeroing failed
  input wire logic          busy,                   // pending
  input wire logic          meas_start,             // acquire pulse
  input wire logic          block_abort,            // block end pulse
  input wire logic          zero_start,             // zeroing pulse
  input wire logic          exec_err,               // error pulse
  input wire logic [7:0]    esr_bits,               // event bits
  input wire logic [7:0]    service_request_enable, // enable register
  input wire logic          trigger_source_select,  // trigger source
  input wire logic          diag_push,              // diag push
  input wire logic          inst_reset,             // reset pulse
  input wire logic          rsp_valid,              // response waiting
  input wire dmmci_rsp_type rsp_kind,               // response kind
  input wire logic [15:0]   rsp_data                // response value
);
  logic go;     // command taken while idle
  logic acq_r;  // acquisition outstanding
  logic zro_r;  // zeroing outstanding
  assign go = cmd_valid && !busy;
  // acquisition seen started
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) acq_r <= 1'b0;
    else if (meas_start) acq_r <= 1'b1;
    else if (meas_done) acq_r <= 1'b0;
  end
  // zeroing seen started
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) zro_r <= 1'b0;
    else if (zero_start) zro_r <= 1'b1;
    else if (zero_done) zro_r <= 1'b0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // error pulse, then sticky bit
  sequence s_err; exec_err ##[0:1] esr_bits[4]; endsequence
  sequence s_dflt;
    inst_reset ##[0:1] (service_request_enable == 8'h00 && !trigger_source_select);
  endsequence
  property p_trig;
    go && cmd_op == DMMCI_CMD_TRIG_READ && !trig_ext_sel |=> meas_start && block_abort;
  endproperty
  property p_read;
    meas_done && acq_r && !meas_open && !meas_overload |=>
      rsp_valid && rsp_kind == DMMCI_RSP_READING && rsp_data == $past(meas_value);
  endproperty
  property p_open; meas_done && acq_r && meas_open |=> exec_err && rsp_kind == DMMCI_RSP_OPEN;
  endproperty
  property p_over;
    meas_done && acq_r && meas_overload && !meas_open |=> rsp_kind == DMMCI_RSP_OVERLOAD;
  endproperty
  property p_zero;
    zero_done && zro_r |=>
      rsp_valid && rsp_data == {15'h0000, $past(zero_err)} && diag_push == $past(zero_err);
  endproperty
  property p_zero_bad; go && cmd_op == DMMCI_CMD_ZERO && (autorange || ac_func) |=> s_err;
  endproperty
  property p_pud_bad;
    go && cmd_op == DMMCI_CMD_PUD_STORE && (pud_protect || cmd_arg > PUD_DEPTH) |=> s_err;
  endproperty
  property p_sre_bad; go && cmd_op == DMMCI_CMD_SRE_WR && cmd_arg > 16'h00ff |=> s_err;
  endproperty
  property p_sre_wr;
    go && cmd_op == DMMCI_CMD_SRE_WR && cmd_arg <= 16'h00ff |=>
      service_request_enable == ($past(cmd_arg[7:0]) & DMMCI_SRE_USED);
  endproperty
  property p_sre_qry;
    go && cmd_op == DMMCI_CMD_SRE_QRY |=>
      rsp_valid && rsp_data == {8'h00, service_request_enable & 8'hbf};
  endproperty
  property p_reset; go && cmd_op == DMMCI_CMD_RESET |=> s_dflt; endproperty
  a_trig: assert property (p_trig)
    else $error("trigger query did not start an acquisition");
  a_read: assert property (p_read)
    else $error("reading response wrong");
  a_open: assert property (p_open)
    else $error("open input response wrong");
  a_over: assert property (p_over)
    else $error("overload response wrong");
  a_zero: assert property (p_zero)
    else $error("zero response or diag push wrong");
  a_zero_bad: assert property (p_zero_bad)
    else $error("zero accepted in autorange or ac");
  a_pud_bad: assert property (p_pud_bad)
    else $error("bad user-data store not refused");
  a_sre_bad: assert property (p_sre_bad)
    else $error("out of range enable not refused");
  a_sre_wr: assert property (p_sre_wr)
    else $error("enable register holds wrong bits");
  a_sre_qry: assert property (p_sre_qry)
    else $error("enable query value wrong");
  a_reset: assert property (p_reset)
    else $error("reset command did not restore defaults");
endmodule // dmmci_top_asserts
bind dmmci_top dmmci_top_asserts #(.PUD_DEPTH(PUD_DEPTH)) i_dmmci_top_asserts (.*);
`default_nettype wire

//--- testbench/dmmci_top_test.sv
// dmmci_top_test: self-checking bench for the command interpreter.
// assumes dmmci_cmdr plays the commander; this module plays the front end.
`default_nettype none
module dmmci_top_test
  import dmmci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4; // short user area keeps recall brief
  logic mclk, rst_n, cmd_valid, pud_byte_valid, pud_protect, autorange, ac_func, trig_ext_sel;
  logic meas_done, meas_open, meas_overload, zero_done, zero_err, rsp_ack, slow;
  logic busy, meas_start, block_abort, zero_start, trigger_source_select, diag_push;
  logic exec_err, rsp_valid, inst_reset;
  logic [15:0] cmd_arg, meas_value, zero_code, diag_code, rsp_data, diag_last, v;
  logic [7:0]  pud_byte, esr_other, esr_bits, service_request_enable, status_byte, sre_m;
  logic [7:0]  pud_m[DEPTH]; // model of the user-data store
  logic [31:0] seed;         // xorshift state
  dmmci_cmd_type cmd_op;
  dmmci_rsp_type rsp_kind;
  int failures, checks, exec_m, exec_n, ms_n, ba_n;
  int zs_n, ir_n, diag_n;
  dmmci_top #(.PUD_DEPTH(DEPTH)) i_dmmci_top (.*);
  dmmci_cmdr i_dmmci_cmdr (.*);
  always #5 mclk = ~mclk;
  // count design pulses against the model
  always @(posedge mclk) begin
    if (exec_err === 1'b1) exec_n++;
    if (meas_start === 1'b1) ms_n++;
    if (block_abort === 1'b1) ba_n++;
    if (zero_start === 1'b1) zs_n++;
    if (inst_reset === 1'b1) ir_n++;
    if (diag_push === 1'b1) begin
      diag_n++;
      diag_last = diag_code;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // bounded wait until nothing pending
  task automatic idle;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (busy === 1'b0 && rsp_valid === 1'b0 && rsp_ack === 1'b0) break;
    end
    @(posedge mclk);
  endtask
  task automatic pop(input dmmci_rsp_type k, input logic [15:0] d, input bit use_d);
    logic [18:0] r;
    r = (i_dmmci_cmdr.got_q.size() > 0) ? i_dmmci_cmdr.got_q.pop_front() : 19'h7_ffff;
    check("rsp_kind", k, r[18:16]);
    if (use_d) check("rsp_data", d, r[15:0]);
  endtask
  // front-end done pulse, one cycle wide
  task automatic done_pulse(input bit zero);
    if (zero) zero_done <= 1'b1;
    else meas_done <= 1'b1;
    @(posedge mclk);
    zero_done <= 1'b0;
    meas_done <= 1'b0;
  endtask
  task automatic recall;
    i_dmmci_cmdr.send(DMMCI_CMD_PUD_QRY, 16'h0000);
    idle();
    for (int b = 0; b < DEPTH; b++) pop(DMMCI_RSP_PUD_BYTE, {8'h00, pud_m[b]}, 1);
  endtask
  task automatic give_verdict;
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, well past the run length
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
  initial begin
    {mclk, rst_n, pud_protect, autorange, ac_func, trig_ext_sel, meas_done} = '0;
    {meas_open, meas_overload, zero_done, zero_err, slow, esr_other} = '0;
    {meas_value, zero_code, sre_m} = '0;
    seed = 32'h0000_35ad;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    idle();
    check("sre_rst", 8'h00, service_request_enable);
    check("trig_src", 1'b0, trigger_source_select);
    // enable: both ends, one past, random
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00ff : (i == 2) ? 16'h0100 : {8'h00, seed[7:0]};
      i_dmmci_cmdr.send(DMMCI_CMD_SRE_WR, v);
      if (v > 16'h00ff) exec_m++;
      else sre_m = v[7:0] & 8'h70;
      i_dmmci_cmdr.send(DMMCI_CMD_SRE_QRY, 16'h0000);
      idle();
      pop(DMMCI_RSP_INTEGER, {8'h00, sre_m & 8'hbf}, 1);
      check("sre_reg", sre_m, service_request_enable);
      check("stb7", sre_m[5], status_byte[7]);
    end
    check("esr_exe", 1'b1, esr_bits[4]);
    // trigger: reading with opc, open, overload
    for (int c = 0; c < 3; c++) begin
      seed = xs(seed);
      meas_value    <= seed[15:0];
      meas_open     <= (c == 1);
      meas_overload <= (c == 2);
      i_dmmci_cmdr.send(DMMCI_CMD_TRIG_READ, 16'h0000);
      if (c == 0) i_dmmci_cmdr.send(DMMCI_CMD_OPC, 16'h0000);
      if (c == 0) check("opc_early", 1'b0, esr_bits[0]);
      done_pulse(0);
      idle();
      pop(c == 0 ? DMMCI_RSP_READING : c == 1 ? DMMCI_RSP_OPEN : DMMCI_RSP_OVERLOAD,
          meas_value, c == 0);
      if (c == 1) exec_m++;
    end
    check("opc_bit", 1'b1, esr_bits[0]);
    check("starts", 3, ms_n);
    check("aborts", 3, ba_n);
    i_dmmci_cmdr.send(DMMCI_CMD_OPC_QRY, 16'h0000);
    idle();
    pop(DMMCI_RSP_INTEGER, 16'h0001, 1);
    // zero: refused twice, clean, errors
    for (int c = 0; c < 4; c++) begin
      seed = xs(seed);
      autorange <= (c == 0);
      ac_func   <= (c == 1);
      zero_err  <= (c == 3);
      zero_code <= seed[15:0];
      i_dmmci_cmdr.send(DMMCI_CMD_ZERO, 16'h0000);
      if (c < 2) exec_m++;
      else begin
        done_pulse(1);
        idle();
        pop(DMMCI_RSP_INTEGER, (c == 3) ? 16'h0001 : 16'h0000, 1);
      end
    end
    check("zero_starts", 2, zs_n);
    check("diag_n", 1, diag_n);
    check("diag_code", zero_code, diag_last);
    // user data: protected, oversized, full, short
    slow <= 1'b1;
    pud_protect <= 1'b1;
    i_dmmci_cmdr.send(DMMCI_CMD_PUD_STORE, 16'h0002);
    pud_protect <= 1'b0;
    i_dmmci_cmdr.send(DMMCI_CMD_PUD_STORE, 16'(DEPTH + 1));
    exec_m += 2;
    for (int n = DEPTH; n > 1; n -= 2) begin
      i_dmmci_cmdr.send(DMMCI_CMD_PUD_STORE, 16'(n));
      for (int b = 0; b < n; b++) begin
        seed = xs(seed);
        pud_m[b] = seed[7:0];
        i_dmmci_cmdr.put_byte(seed[7:0]);
      end
      idle();
      recall();
    end
    // reset command keeps user data
    i_dmmci_cmdr.send(DMMCI_CMD_RESET, 16'h0000);
    idle();
    check("inst_reset", 1, ir_n);
    check("sre_clr", 8'h00, service_request_enable);
    check("esr_clr", 8'h00, esr_bits);
    recall();
    check("exec_n", exec_m, exec_n);
    give_verdict();
  end
endmodule // dmmci_top_test
`default_nettype wire
